// ---- include/dsrp_pkg.sv ----
// shared constants of the dual serial register port, both ends
// assumes a 25 MHz system clock on each end
`default_nettype none
package dsrp_pkg;

  // bus rates and the derived clock-cycle counts
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned I2C_MAX_HZ = 400_000;
  localparam int unsigned SPI_MAX_HZ = 8_000_000;
  // quarter of the two-wire period, rounded up so the rate stays legal
  localparam int unsigned I2C_QTR =
    (CLK_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ);
  // half of the four-wire period, rounded up likewise
  localparam int unsigned SPI_HALF =
    (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
  localparam logic [4:0] I2C_QTR_LIM  = 5'(I2C_QTR - 1);
  localparam logic [4:0] SPI_HALF_LIM = 5'(SPI_HALF - 1);

  // address and framing
  localparam logic [5:0] I2C_ADDR_HI    = 6'h34;
  localparam logic       RW_WRITE       = 1'b0;
  localparam logic       RW_READ        = 1'b1;
  localparam logic [3:0] I2C_ACK_BIT    = 4'h8;
  localparam logic [2:0] BYTE_LAST      = 3'h7;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  // kind of the byte that the slave receives next
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR  = 2'h1,
    K_DATA = 2'h2
  } dsrp_kind_type;

endpackage
`default_nettype wire

// ---- include/dsrp_link_if.sv ----
// shared pins between host and device: scl/sclk, sda/sdi, sel/sdo, cs
// assumes the bench drives strap_level, the board level of the select pin
`timescale 1ns/1ps
`default_nettype none
interface dsrp_link_if;
  logic host_scl_oe;
  logic host_scl_o;
  logic host_sda_oe;
  logic host_sda_o;
  logic chip_sel_n;
  logic dev_scl_oe;
  logic dev_sda_oe;
  logic dev_sdo_oe;
  logic serial_out_pin;
  logic strap_level;
  logic scl;
  logic sda;
  logic address_select_pin;

  // pull-ups on scl and sda, which the device only pulls low; sdo it drives both ways
  assign scl = (host_scl_oe ? host_scl_o : 1'b1) & ~dev_scl_oe;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & ~dev_sda_oe;
  assign address_select_pin = dev_sdo_oe ? serial_out_pin : strap_level;

  modport dev (
    input  scl,
    input  sda,
    input  chip_sel_n,
    input  address_select_pin,
    output dev_scl_oe,
    output dev_sda_oe,
    output dev_sdo_oe,
    output serial_out_pin
  );

  modport host (
    input  scl,
    input  sda,
    input  address_select_pin,
    output host_scl_oe,
    output host_scl_o,
    output host_sda_oe,
    output host_sda_o,
    output chip_sel_n
  );
endinterface
`default_nettype wire

// ---- src/dsrp_device.sv ----
// sensor end of the dual serial register port: two-wire slave on clk,
// four-wire slave on the link clock sclk
// assumes a register file on each user port; two-wire reads answer
// by reg_rvalid, four-wire reads are combinational on spi_rdata
//
// How it works
// RL1: registers reachable over two-wire or four-wire
// RL2: host sets two-wire disable when using four-wire; the bench drives it instead, and the four-wire test also runs with it clear
// RL3: two-wire side is always slave, 400 kHz
// RL4: address high six fixed, low from pin
// RL5: start and stop detected while scl high
// RL6: bus busy from start until stop
// RL7: master changes sda only while scl low
// RL8: eight-bit bytes, each followed by acknowledge
// RL9: receiver holds sda low on ninth clock
// RL10: slave may hold scl low; master waits
// RL11: address then direction bit, then acknowledge
// RL12: write acks address, pointer and data bytes
// RL13: further write bytes go to next pointer
// RL14: read via pointer write, repeated start, read
// RL15: master acks for more, nacks the last
// RL16: four-wire slave only, framed by chip select
// RL17: serial output floats while chip select high
// RL18: host drives only one chip select
// RL19: first bit direction, seven address bits follow
// RL20: msb first, sample rising, change falling
// RL21: disabled two-wire ignores starts and addresses
`timescale 1ns/1ps
`default_nettype none
module dsrp_device (
  input  wire logic       clk,
  input  wire logic       rstn,
  dsrp_link_if.dev        lnk,
  input  wire logic       two_wire_port_disable,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_we,
  output logic            reg_re,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            bus_busy,
  output logic [6:0]      spi_waddr,
  output logic [7:0]      spi_wdata,
  output logic            spi_we,
  output logic [6:0]      spi_raddr,
  input  wire logic [7:0] spi_rdata
);
  import dsrp_pkg::*;

  typedef enum logic [2:0] {
    I_IDLE  = 3'b000,
    I_RX    = 3'b001,
    I_ACK   = 3'b011,
    I_FETCH = 3'b010,
    I_TX    = 3'b110,
    I_RACK  = 3'b111
  } dsrp_i2c_state_type;

  logic               scl_m;
  logic               sda_m;
  logic               cs_m;
  logic               sel_m;
  logic               scl_s;
  logic               sda_s;
  logic               cs_s;
  logic               sel_s;
  logic               scl_p;
  logic               sda_p;
  dsrp_i2c_state_type st_q;
  dsrp_kind_type      kind_q;
  logic [3:0]         cnt_q;
  logic [7:0]         sh_q;
  logic [7:0]         ptr_q;
  logic               rw_q;
  logic               ack_q;
  logic               sel_q;
  logic               sda_oe_q;
  logic               scl_oe_q;
  logic               busy_q;
  logic               we_q;
  logic               re_q;
  logic [7:0]         wd_q;

  // pin synchronisers for the two-wire slave
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {scl_m, sda_m, cs_m, sel_m} <= 4'hf;
      {scl_s, sda_s, cs_s, sel_s} <= 4'hf;
      {scl_p, sda_p}              <= 2'h3;
    end else begin
      {scl_m, sda_m} <= {lnk.scl, lnk.sda};
      {cs_m, sel_m}  <= {lnk.chip_sel_n, lnk.address_select_pin};
      {scl_s, sda_s, cs_s, sel_s} <= {scl_m, sda_m, cs_m, sel_m};
      {scl_p, sda_p} <= {scl_s, sda_s};
    end
  end

  // mode, edge and condition decode
  wire i2c_en   = cs_s & ~two_wire_port_disable; // RL1 RL2 RL21
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_c  = i2c_en & scl_s & scl_p & sda_p & ~sda_s; // RL5
  wire stop_c   = i2c_en & scl_s & scl_p & ~sda_p & sda_s; // RL5
  wire addr_hit = (sh_q[7:1] == {I2C_ADDR_HI, sel_q}); // RL4
  wire byte_end = scl_fall & (cnt_q == I2C_ACK_BIT); // RL8
  wire tx_done  = (cnt_q[2:0] == BYTE_LAST);

  // two-wire slave state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= I_IDLE;
      kind_q   <= K_ADDR;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= RW_WRITE;
      ack_q    <= 1'b0;
      sel_q    <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      busy_q   <= 1'b0;
      we_q     <= 1'b0;
      re_q     <= 1'b0;
      wd_q     <= 8'h00;
    end else begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      if (!i2c_en) begin
        st_q     <= I_IDLE; // RL21
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        busy_q   <= 1'b0;
      end else if (start_c) begin
        // a repeated start lands here too and keeps the pointer
        st_q     <= I_RX; // RL14
        kind_q   <= K_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        busy_q   <= 1'b1; // RL6
      end else if (stop_c) begin
        st_q     <= I_IDLE;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        busy_q   <= 1'b0; // RL6
      end else begin
        case (st_q)
          I_IDLE: begin
            sel_q <= sel_s; // RL4
          end
          I_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s}; // RL7 RL3
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_end) begin
              cnt_q <= 4'h0;
              if (kind_q == K_ADDR) begin
                if (addr_hit) begin
                  rw_q     <= sh_q[0]; // RL11
                  sda_oe_q <= 1'b1; // RL12
                  st_q     <= I_ACK;
                end else begin
                  st_q <= I_IDLE;
                end
              end else begin
                sda_oe_q <= 1'b1; // RL9 RL12
                st_q     <= I_ACK;
                if (kind_q == K_PTR) begin
                  ptr_q <= sh_q;
                end else begin
                  we_q <= 1'b1;
                  wd_q <= sh_q;
                end
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0; // RL9
              if (rw_q == RW_READ) begin
                st_q     <= I_FETCH; // RL14
                re_q     <= 1'b1;
                scl_oe_q <= 1'b1; // RL10
              end else begin
                st_q <= I_RX;
                if (kind_q == K_DATA) begin
                  ptr_q <= ptr_q + 8'h01; // RL13
                end
                kind_q <= (kind_q == K_ADDR) ? K_PTR : K_DATA;
              end
            end
          end
          I_FETCH: begin
            // scl held low until the register file answers
            if (reg_rvalid) begin
              sh_q     <= reg_rdata;
              sda_oe_q <= ~reg_rdata[7];
              scl_oe_q <= 1'b0; // RL10
              ptr_q    <= ptr_q + 8'h01;
              cnt_q    <= 4'h0;
              st_q     <= I_TX;
            end
          end
          I_TX: begin
            if (scl_fall) begin
              if (tx_done) begin
                sda_oe_q <= 1'b0;
                st_q     <= I_RACK;
              end else begin
                sda_oe_q <= ~sh_q[6];
                sh_q     <= {sh_q[6:0], 1'b0};
                cnt_q    <= cnt_q + 4'h1;
              end
            end
          end
          I_RACK: begin
            if (scl_rise) begin
              ack_q <= ~sda_s; // RL15
            end else if (scl_fall) begin
              if (ack_q) begin
                st_q     <= I_FETCH;
                re_q     <= 1'b1;
                scl_oe_q <= 1'b1; // RL10
              end else begin
                st_q <= I_IDLE; // RL15
              end
            end
          end
          default: begin
            st_q <= I_IDLE;
          end
        endcase
      end
    end
  end

  // two-wire user side and pin drive
  assign reg_addr       = ptr_q;
  assign reg_wdata      = wd_q;
  assign reg_we         = we_q;
  assign reg_re         = re_q;
  assign bus_busy       = busy_q;
  assign lnk.dev_sda_oe = sda_oe_q;
  assign lnk.dev_scl_oe = scl_oe_q;

  // four-wire slave, clocked by sclk, reset while deselected
  logic       s_hdr_q;
  logic       s_rw_q;
  logic [2:0] s_cnt_q;
  logic [6:0] s_sh_q;
  logic [6:0] s_ptr_q;
  logic [6:0] s_wa_q;
  logic [7:0] s_wd_q;
  logic       s_we_q;
  logic [7:0] s_tx_q;

  wire spi_rst_n = rstn & ~lnk.chip_sel_n; // RL16
  wire s_byte    = (s_cnt_q == BYTE_LAST);
  wire s_load    = (s_cnt_q == 3'h0) & ~s_hdr_q;

  // receive on the rising edge, msb first
  always_ff @(posedge lnk.scl or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      s_hdr_q <= 1'b1;
      s_rw_q  <= RW_WRITE;
      s_cnt_q <= 3'h0;
      s_sh_q  <= 7'h00;
      s_ptr_q <= 7'h00;
      s_wa_q  <= 7'h00;
      s_wd_q  <= 8'h00;
      s_we_q  <= 1'b0;
    end else begin
      s_cnt_q <= s_cnt_q + 3'h1;
      s_sh_q  <= {s_sh_q[5:0], lnk.sda}; // RL20
      s_we_q  <= 1'b0;
      if (s_byte) begin
        s_hdr_q <= 1'b0;
        if (s_hdr_q) begin
          {s_rw_q, s_ptr_q} <= {s_sh_q, lnk.sda}; // RL19
        end else begin
          if (s_rw_q == RW_WRITE) begin
            s_we_q <= 1'b1;
            s_wa_q <= s_ptr_q;
            s_wd_q <= {s_sh_q, lnk.sda};
          end
          s_ptr_q <= s_ptr_q + 7'h01; // burst
        end
      end
    end
  end

  // transmit on the falling edge, next byte loaded at a boundary
  always_ff @(negedge lnk.scl or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      s_tx_q <= 8'h00;
    end else if (s_load) begin
      s_tx_q <= spi_rdata; // RL20
    end else begin
      s_tx_q <= {s_tx_q[6:0], 1'b0}; // RL20
    end
  end

  // four-wire user side and output pin
  assign spi_waddr          = s_wa_q;
  assign spi_wdata          = s_wd_q;
  assign spi_we             = s_we_q;
  assign spi_raddr          = s_ptr_q;
  assign lnk.serial_out_pin = s_tx_q[7];
  assign lnk.dev_sdo_oe     = s_rw_q & ~s_hdr_q; // RL17 RL18
endmodule
`default_nettype wire

// ---- src/dsrp_host.sv ----
// processor end of the dual serial register port: one register
// transfer per command, over two-wire or four-wire
// assumes one device on the link; the link clock is divided from clk
`timescale 1ns/1ps
`default_nettype none
module dsrp_host (
  input  wire logic       clk,
  input  wire logic       rstn,
  dsrp_link_if.host       lnk,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_spi,
  input  wire logic       cmd_read,
  input  wire logic       cmd_dev_sel,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_nack
);
  import dsrp_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_I2C  = 2'b01,
    H_SPI  = 2'b11
  } dsrp_host_state_type;

  typedef enum logic [1:0] {
    IT_START = 2'h0,
    IT_TX    = 2'h1,
    IT_RX    = 2'h2,
    IT_STOP  = 2'h3
  } dsrp_item_type;

  // two-wire sequence: S AW RA D P, or S AW RA Sr AR DATA P
  function automatic dsrp_item_type item_of(input logic rd,
                                            input logic [2:0] st);
    case (st)
      3'h0:    item_of = IT_START;
      3'h1:    item_of = IT_TX;
      3'h2:    item_of = IT_TX;
      3'h3:    item_of = rd ? IT_START : IT_TX;
      3'h4:    item_of = rd ? IT_TX : IT_STOP;
      3'h5:    item_of = rd ? IT_RX : IT_STOP;
      default: item_of = IT_STOP;
    endcase
  endfunction

  dsrp_host_state_type st_q;
  logic       scl_m;
  logic       sda_m;
  logic       miso_m;
  logic       scl_s;
  logic       sda_s;
  logic       miso_s;
  logic [4:0] div_q;
  logic [1:0] ph_q;
  logic [2:0] step_q;
  logic [4:0] bit_q;
  logic       rd_q;
  logic       sel_q;
  logic [7:0] reg_q;
  logic [7:0] wd_q;
  logic [15:0] spi_sh_q;
  logic [7:0] rx_q;
  logic       nack_q;
  logic       rsp_q;
  logic       scl_oe_q;
  logic       scl_o_q;
  logic       sda_oe_q;
  logic       sda_o_q;
  logic       cs_n_q;

  // link pins back into clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {scl_m, sda_m, miso_m} <= 3'h7;
      {scl_s, sda_s, miso_s} <= 3'h7;
    end else begin
      {scl_m, sda_m, miso_m} <= {lnk.scl, lnk.sda, lnk.address_select_pin};
      {scl_s, sda_s, miso_s} <= {scl_m, sda_m, miso_m};
    end
  end

  // phase tick, byte selection and bit decode
  dsrp_item_type item;
  logic [7:0]    cur_byte;
  assign item     = item_of(rd_q, step_q);
  assign cur_byte = (step_q == 3'h1) ? {I2C_ADDR_HI, sel_q, RW_WRITE} :
                    (step_q == 3'h2) ? reg_q :
                    (step_q == 3'h3) ? wd_q :
                    {I2C_ADDR_HI, sel_q, RW_READ}; // RL11 RL14
  wire       tick     = (div_q == 5'h00);
  wire [4:0] lim      = (st_q == H_SPI) ? SPI_HALF_LIM : I2C_QTR_LIM; // RL1
  wire       ack_bit  = (bit_q[3:0] == I2C_ACK_BIT); // RL8
  wire       tx_bit   = cur_byte[3'(BYTE_LAST - bit_q[2:0])];
  wire       adv      = tick & ~((ph_q == 2'h2) & ~scl_s); // RL10
  wire [2:0] stop_idx = rd_q ? 3'h6 : 3'h4;

  // command engine for both buses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= H_IDLE;
      div_q <= 5'h00;
      ph_q <= 2'h0;
      step_q <= 3'h0;
      bit_q <= 5'h00;
      {rd_q, sel_q, reg_q, wd_q} <= 18'h00000;
      spi_sh_q <= 16'h0000;
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      rsp_q <= 1'b0;
      {scl_oe_q, scl_o_q, sda_oe_q, sda_o_q} <= 4'h0;
      cs_n_q <= 1'b1;
    end else begin
      rsp_q <= 1'b0;
      div_q <= tick ? lim : div_q - 5'h01;
      case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            {rd_q, sel_q, reg_q, wd_q} <=
              {cmd_read, cmd_dev_sel, cmd_reg, cmd_wdata};
            spi_sh_q <= {cmd_read, cmd_reg[6:0],
                         cmd_read ? 8'h00 : cmd_wdata}; // RL19
            {ph_q, step_q, bit_q, nack_q} <= 11'h000;
            st_q <= cmd_spi ? H_SPI : H_I2C;
            {scl_oe_q, scl_o_q, sda_oe_q, sda_o_q} <=
              cmd_spi ? 4'he : 4'h0;
            cs_n_q <= ~cmd_spi; // RL16 RL18
          end
        end
        H_I2C: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin
                // sda moves only while scl low
                sda_oe_q <= (item == IT_STOP) |
                            ((item == IT_TX) & ~ack_bit & ~tx_bit); // RL7
              end
              2'h1: begin
                scl_oe_q <= 1'b0;
              end
              2'h2: begin
                if (item == IT_START) begin
                  sda_oe_q <= 1'b1; // RL5
                end else if (item == IT_STOP) begin
                  sda_oe_q <= 1'b0; // RL5
                end else if (ack_bit) begin
                  nack_q <= nack_q | ((item == IT_TX) & sda_s); // RL9
                end else if (item == IT_RX) begin
                  rx_q <= {rx_q[6:0], sda_s};
                end
              end
              default: begin
                if (item == IT_STOP) begin
                  st_q  <= H_IDLE;
                  rsp_q <= 1'b1;
                end else begin
                  scl_oe_q <= 1'b1;
                  if ((item == IT_START) | ack_bit) begin
                    bit_q  <= 5'h00;
                    step_q <= (nack_q | ((item == IT_TX) & sda_s)) ?
                              stop_idx : step_q + 3'h1; // RL15
                  end else begin
                    bit_q <= bit_q + 5'h01;
                  end
                end
              end
            endcase
          end
        end
        H_SPI: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (!ph_q[0]) begin
              if (bit_q != 5'h00) begin
                rx_q <= {rx_q[6:0], miso_s};
              end
              if (bit_q == SPI_FRAME_BITS) begin
                cs_n_q   <= 1'b1;
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                st_q     <= H_IDLE;
                rsp_q    <= 1'b1;
              end else begin
                scl_o_q  <= 1'b0;
                sda_o_q  <= spi_sh_q[15]; // RL20
                spi_sh_q <= {spi_sh_q[14:0], 1'b0};
              end
            end else begin
              scl_o_q <= 1'b1; // RL20
              bit_q   <= bit_q + 5'h01;
            end
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  // user side and pin drive
  assign cmd_ready       = (st_q == H_IDLE);
  assign rsp_valid       = rsp_q;
  assign rsp_data        = rx_q;
  assign rsp_nack        = nack_q;
  assign lnk.host_scl_oe = scl_oe_q;
  assign lnk.host_scl_o  = scl_o_q;
  assign lnk.host_sda_oe = sda_oe_q;
  assign lnk.host_sda_o  = sda_o_q;
  assign lnk.chip_sel_n  = cs_n_q;
endmodule
`default_nettype wire

// ---- include/dsrp_none.sv ----
// holds no definitions; shared constants live in dsrp_pkg, the link in dsrp_link_if

// ---- tb/dsrp_link_monitor.sv ----
// checker on the shared link pins of the register port
// assumes the bench wires it beside the link and the system clock
`timescale 1ns/1ps
`default_nettype none
module dsrp_link_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic chip_sel_n,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_sdo_oe,
  input wire logic serial_out_pin
);
  logic       scl_q;
  logic [4:0] rise_cnt_q;
  logic [4:0] rise_cnt_d;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // count link clock rises inside a four-wire frame
  assign rise_cnt_d = chip_sel_n ? 5'h00 :
                      rise_cnt_q + {4'h0, scl & ~scl_q};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q      <= 1'b1;
      rise_cnt_q <= 5'h00;
    end else begin
      scl_q      <= scl;
      rise_cnt_q <= rise_cnt_d;
    end
  end

  property p_sdo_float;
    chip_sel_n && $past(chip_sel_n) |-> !dev_sdo_oe;
  endproperty
  a_sdo_float: assert property (p_sdo_float)
    else $error("sdo driven while deselected");

  property p_quiet_frame;
    (!chip_sel_n) [*4] |-> !dev_sda_oe && !dev_scl_oe;
  endproperty
  a_quiet_frame: assert property (p_quiet_frame)
    else $error("two-wire pins pulled in a four-wire frame");

  property p_sda_hold;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("device moved sda while scl high");

  property p_stretch_low;
    $rose(dev_scl_oe) |-> !$past(scl);
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("device grabbed scl while high");

  property p_stretch_end;
    dev_scl_oe |-> ##[0:1000] !dev_scl_oe;
  endproperty
  a_stretch_end: assert property (p_stretch_end)
    else $error("scl held low too long");

  property p_sdo_shift;
    !chip_sel_n && dev_sdo_oe && $past(dev_sdo_oe)
      && $changed(serial_out_pin) |-> !scl;
  endproperty
  a_sdo_shift: assert property (p_sdo_shift)
    else $error("sdo changed while sclk high");

  property p_sdo_after_hdr;
    $rose(dev_sdo_oe) |-> rise_cnt_q == 5'h07 || rise_cnt_q == 5'h08;
  endproperty
  a_sdo_after_hdr: assert property (p_sdo_after_hdr)
    else $error("sdo enabled before header end");

  property p_stop_idle;
    chip_sel_n && scl && $past(scl) && $rose(sda)
      |-> ##4 !dev_sda_oe && !dev_scl_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("device still driving after stop");
endmodule
`default_nettype wire

// ---- tb/dual_serial_register_port_test.sv ----
// self-checking bench: host end and device end joined by the link
// assumes one 25 MHz clock; the link clock comes from the host divider
`timescale 1ns/1ps
`default_nettype none
module dual_serial_register_port_test;
  import dsrp_pkg::*;
  logic       clk;
  logic       rstn;
  logic       two_wire_port_disable;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_we;
  logic       reg_re;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       bus_busy;
  logic [6:0] spi_waddr;
  logic [7:0] spi_wdata;
  logic       spi_we;
  logic [6:0] spi_raddr;
  logic [7:0] spi_rdata;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_spi;
  logic       cmd_read;
  logic       cmd_dev_sel;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_wdata;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       saw_busy;
  logic [7:0] tw_mem [256];
  logic [7:0] sp_mem [128];
  int         fail_count;
  int         checked;

  dsrp_link_if lnk ();
  dsrp_device u_dsrp_device (.clk(clk), .rstn(rstn), .lnk(lnk),
    .two_wire_port_disable(two_wire_port_disable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bus_busy(bus_busy),
    .spi_waddr(spi_waddr), .spi_wdata(spi_wdata), .spi_we(spi_we),
    .spi_raddr(spi_raddr), .spi_rdata(spi_rdata));
  dsrp_host u_dsrp_host (.clk(clk), .rstn(rstn), .lnk(lnk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_spi(cmd_spi),
    .cmd_read(cmd_read), .cmd_dev_sel(cmd_dev_sel), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));
  dsrp_link_monitor u_dsrp_link_monitor (.clk(clk), .rstn(rstn),
    .scl(lnk.scl), .sda(lnk.sda), .chip_sel_n(lnk.chip_sel_n),
    .dev_scl_oe(lnk.dev_scl_oe), .dev_sda_oe(lnk.dev_sda_oe),
    .dev_sdo_oe(lnk.dev_sdo_oe), .serial_out_pin(lnk.serial_out_pin));

  // register files behind both user ports; two-wire answers a cycle late
  assign reg_rdata = tw_mem[reg_addr];
  assign spi_rdata = sp_mem[spi_raddr];
  always @(posedge clk) begin
    reg_rvalid <= reg_re;
    if (reg_we === 1'b1)
      tw_mem[reg_addr] <= reg_wdata;
    if (spi_we === 1'b1)
      sp_mem[spi_waddr] <= spi_wdata;
    if (bus_busy === 1'b1)
      saw_busy <= 1'b1;
  end

  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2_400_000;
    fail_count++;
    finish_test();
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one host command, then its answer against the expected byte and nack
  task automatic xfer(input logic s, input logic r, input logic d,
                      input logic [7:0] a, input logic [7:0] w,
                      input logic [7:0] x, input logic n);
    int k;
    @(negedge clk);
    cmd_spi = s;
    cmd_read = r;
    cmd_dev_sel = d;
    cmd_reg = a;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, rsp_valid}, 8'h01);
    chk({7'h00, rsp_nack}, {7'h00, n});
    if (r && !n)
      chk(rsp_data, x);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // reset, then the test sequence
  initial begin
    fail_count = 0;
    checked = 0;
    saw_busy = 1'b0;
    rstn = 1'b0;
    two_wire_port_disable = 1'b0;
    lnk.strap_level = 1'b0;
    cmd_valid = 1'b0;
    cmd_spi = 1'b0;
    cmd_read = 1'b0;
    cmd_dev_sel = 1'b0;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    xfer(0, 0, 0, 8'h10, 8'ha5, 8'h00, 0);
    chk(reg_addr, 8'h11);
    xfer(0, 1, 0, 8'h10, 8'h00, 8'ha5, 0);
    xfer(0, 0, 0, 8'hff, 8'h3c, 8'h00, 0);
    chk(reg_addr, 8'h00);
    xfer(0, 1, 0, 8'hff, 8'h00, 8'h3c, 0);
    chk({7'h00, saw_busy}, 8'h01);
    $display("two-wire test done");
    xfer(0, 0, 1, 8'h10, 8'h55, 8'h00, 1);
    lnk.strap_level = 1'b1;
    xfer(0, 0, 1, 8'h20, 8'h5a, 8'h00, 0);
    xfer(0, 1, 1, 8'h20, 8'h00, 8'h5a, 0);
    xfer(0, 1, 0, 8'h20, 8'h00, 8'h00, 1);
    $display("address test done");
    xfer(1, 0, 0, 8'h05, 8'hc3, 8'h00, 0);
    xfer(1, 0, 0, 8'h7f, 8'h81, 8'h00, 0);
    xfer(1, 1, 0, 8'h05, 8'h00, 8'hc3, 0);
    xfer(1, 1, 0, 8'h7f, 8'h00, 8'h81, 0);
    $display("four-wire test done");
    two_wire_port_disable = 1'b1;
    saw_busy = 1'b0;
    xfer(0, 0, 1, 8'h20, 8'hee, 8'h00, 1);
    chk({7'h00, saw_busy}, 8'h00);
    xfer(1, 0, 0, 8'h06, 8'h99, 8'h00, 0);
    xfer(1, 1, 0, 8'h06, 8'h00, 8'h99, 0);
    two_wire_port_disable = 1'b0;
    xfer(0, 1, 1, 8'h20, 8'h00, 8'h5a, 0);
    $display("disable test done");
    finish_test();
  end
endmodule
`default_nettype wire
